// ==== core/boeu_top.sv ====
// Behaviour
// - increment_file adds one, only zero flag
// - dest bit 0 to W, 1 to file
// - or_with_file ORs W with file, zero flag
// - move_file copies file to dest, zero flag
// - move_file to file rewrites it, tests zero
// - load_literal puts 8-bit immediate in W
// - return_from_interrupt loads PC, sets interrupt enable
// - store_working_register writes W to file
// - return_with_literal loads W with the literal and PC from stack
// - return_with_literal takes two instruction cycles
// - rotate left through carry, only carry affected
`timescale 1ns/100ps
`default_nettype none
module boeu_top
    import boeu_pkg::*;
#(
    parameter int FILE_DEPTH = FILE_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic busy,
    output logic globalInterruptEnable,
    output logic [PC_W-1:0] progCounter
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    localparam int RAM_AW = (FILE_DEPTH > 1) ? $clog2(FILE_DEPTH) : 1;

    if (FILE_DEPTH < 2 || FILE_DEPTH > 128 ||
        (FILE_DEPTH & (FILE_DEPTH - 1)) != 0) begin : gBadDepth
        $error("FILE_DEPTH must be a power of two from 2 to 128");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    boeu_state_e state_ff;
    boeu_state_e nxt_state;
    logic [CMD_W-1:0] cmd_ff;
    logic [DATA_W-1:0] wreg_ff;
    logic zero_ff;
    logic carry_ff;
    logic ien_ff;
    logic [PC_W-1:0] pc_ff;
    logic [PC_W-1:0] stk_ff;
    logic [1:0] holdCnt_ff;
    logic memPend_ff;

    boeu_op_e cmdOp;
    logic [ADDR_W-1:0] cmdAdr;
    logic cmdDst;
    logic [DATA_W-1:0] cmdLit;

    logic idle;
    logic isFile;
    logic statRead;
    logic busWrOk;
    logic busRdOk;
    logic memRdStart;
    logic cmdGo;

    logic [DATA_W-1:0] ramQ;
    logic ramWe;
    logic ramRe;
    logic [ADDR_W-1:0] ramAddr;
    logic [DATA_W-1:0] ramWd;

    logic [DATA_W-1:0] aluRes;
    logic aluZero;
    logic aluCarry;
    logic execStep;
    logic toFile;
    logic engineWr;
    logic isReturn;

    // ----------------------------------------------------------------
    // Byte-lane merge for register writes
    // ----------------------------------------------------------------
    function automatic logic [31:0] beMerge(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction : beMerge

    // ----------------------------------------------------------------
    // Command fields
    // ----------------------------------------------------------------
    assign cmdOp = boeu_op_e'(cmd_ff[CMD_OP_LSB +: CMD_OP_W]);
    assign cmdAdr = cmd_ff[CMD_ADR_LSB +: ADDR_W];
    assign cmdDst = cmd_ff[CMD_DST_BIT];
    assign cmdLit = cmd_ff[CMD_LIT_LSB +: DATA_W];

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    assign idle = (state_ff == ST_IDLE);
    assign isFile = avs_address[FILE_WIN_BIT];
    assign statRead = avs_read && (avs_address == OFS_STAT);

    // Stall while frozen, while busy except for status reads, and for the file read latency
    always_comb begin
        avs_waitrequest = 1'b0;
        if (avs_read || avs_write) begin
            if (!ce) begin
                avs_waitrequest = 1'b1;
            end else if (!idle && !statRead) begin
                avs_waitrequest = 1'b1;
            end else if (avs_read && isFile && !memPend_ff) begin
                avs_waitrequest = 1'b1;
            end
        end
    end

    assign busWrOk = avs_write && !avs_waitrequest;
    assign busRdOk = avs_read && !avs_waitrequest;
    assign memRdStart = ce && idle && avs_read && isFile && !memPend_ff;
    assign cmdGo = busWrOk && (avs_address == OFS_CMD);

    // File read pending flag, one wait cycle per read
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            memPend_ff <= 1'b0;
        end else if (ce) begin
            if (memRdStart) begin
                memPend_ff <= 1'b1;
            end else if (busRdOk) begin
                memPend_ff <= 1'b0;
            end
        end
    end

    // Read data mux of register outputs
    always_comb begin
        avs_readdata = 32'h00000000;
        if (isFile) begin
            avs_readdata[DATA_W-1:0] = ramQ;
        end else begin
            case (avs_address)
                OFS_CMD: avs_readdata[CMD_W-1:0] = cmd_ff;
                OFS_STAT: begin
                    avs_readdata[ST_Z_BIT] = zero_ff;
                    avs_readdata[ST_C_BIT] = carry_ff;
                    avs_readdata[ST_BUSY_BIT] = !idle;
                    avs_readdata[ST_IEN_BIT] = ien_ff;
                end
                OFS_WREG: avs_readdata[DATA_W-1:0] = wreg_ff;
                OFS_PC: avs_readdata[PC_W-1:0] = pc_ff;
                OFS_STK: avs_readdata[PC_W-1:0] = stk_ff;
                default: avs_readdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    assign isReturn = (cmdOp == OP_RETURN_FROM_INTERRUPT) ||
                      (cmdOp == OP_RETURN_WITH_LITERAL);
    assign execStep = ce && (state_ff == ST_EXEC);

    // Fetch then execute form one instruction cycle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cmdGo) begin
                    nxt_state = ST_FETCH;
                end
            end
            ST_FETCH: nxt_state = ST_EXEC;
            ST_EXEC: begin
                if (cmdOp == OP_RETURN_WITH_LITERAL) begin
                    nxt_state = ST_HOLD;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (holdCnt_ff == 2'b00) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Second instruction cycle counter
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            holdCnt_ff <= 2'b00;
        end else if (ce) begin
            if (state_ff == ST_EXEC) begin
                holdCnt_ff <= HOLD_LOAD;
            end else if (state_ff == ST_HOLD && holdCnt_ff != 2'b00) begin
                holdCnt_ff <= holdCnt_ff - 2'b01;
            end
        end
    end

    // Command capture, starts the sequencer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ff <= RST_CMD;
        end else if (ce && cmdGo) begin
            cmd_ff <= CMD_W'(beMerge(32'(cmd_ff), avs_writedata,
                                     avs_byteenable));
        end
    end

    // ----------------------------------------------------------------
    // File register memory and operation unit
    // ----------------------------------------------------------------
    assign toFile = (cmdDst == DEST_F);
    always_comb begin
        engineWr = 1'b0;
        case (cmdOp)
            OP_STORE_WORKING_REGISTER: engineWr = 1'b1;
            OP_INCREMENT_FILE,
            OP_OR_WITH_FILE,
            OP_MOVE_FILE,
            OP_ROTATE_LEFT_THROUGH_CARRY: engineWr = toFile;
            default: engineWr = 1'b0;
        endcase
    end

    // Engine owns the port while busy, the bus while idle
    assign ramAddr = idle ? avs_address[2 +: ADDR_W] : cmdAdr;
    assign ramRe = (ce && state_ff == ST_FETCH) || memRdStart;
    assign ramWe = (execStep && engineWr) ||
                   (busWrOk && isFile && avs_byteenable[0]);
    assign ramWd = idle ? avs_writedata[DATA_W-1:0] : aluRes;

    boeu_file_ram #(
        .WIDTH(DATA_W),
        .DEPTH(FILE_DEPTH),
        .AW(RAM_AW)
    ) uFileRam (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .we(ramWe),
        .re(ramRe),
        .addr(ramAddr[RAM_AW-1:0]),
        .wdata(ramWd),
        .rdata(ramQ)
    );

    boeu_alu uAlu (
        .op(cmdOp),
        .fileVal(ramQ),
        .wVal(wreg_ff),
        .lit(cmdLit),
        .carryIn(carry_ff),
        .result(aluRes),
        .zero(aluZero),
        .carryOut(aluCarry)
    );

    // ----------------------------------------------------------------
    // Architectural state
    // ----------------------------------------------------------------

    // Working register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wreg_ff <= RST_WREG;
        end else if (ce) begin
            if (busWrOk && avs_address == OFS_WREG) begin
                wreg_ff <= DATA_W'(beMerge(32'(wreg_ff), avs_writedata,
                                           avs_byteenable));
            end else if (execStep) begin
                case (cmdOp)
                    OP_LOAD_LITERAL,
                    OP_RETURN_WITH_LITERAL: wreg_ff <= aluRes;
                    OP_INCREMENT_FILE,
                    OP_OR_WITH_FILE,
                    OP_MOVE_FILE,
                    OP_ROTATE_LEFT_THROUGH_CARRY: begin
                        if (!toFile) begin
                            wreg_ff <= aluRes;
                        end
                    end
                    default: wreg_ff <= wreg_ff;
                endcase
            end
        end
    end

    // Zero flag
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            zero_ff <= RST_Z;
        end else if (ce) begin
            if (busWrOk && avs_address == OFS_STAT && avs_byteenable[0]) begin
                zero_ff <= avs_writedata[ST_Z_BIT];
            end else if (execStep) begin
                case (cmdOp)
                    OP_INCREMENT_FILE: zero_ff <= aluZero;
                    OP_OR_WITH_FILE: zero_ff <= aluZero;
                    OP_MOVE_FILE: zero_ff <= aluZero;
                    default: zero_ff <= zero_ff;
                endcase
            end
        end
    end

    // Carry flag
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            carry_ff <= RST_C;
        end else if (ce) begin
            if (busWrOk && avs_address == OFS_STAT && avs_byteenable[0]) begin
                carry_ff <= avs_writedata[ST_C_BIT];
            end else if (execStep &&
                         cmdOp == OP_ROTATE_LEFT_THROUGH_CARRY) begin
                carry_ff <= aluCarry;
            end
        end
    end

    // Global interrupt enable
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ien_ff <= RST_IEN;
        end else if (ce) begin
            if (busWrOk && avs_address == OFS_STAT && avs_byteenable[0]) begin
                ien_ff <= avs_writedata[ST_IEN_BIT];
            end else if (execStep && cmdOp == OP_RETURN_FROM_INTERRUPT) begin
                ien_ff <= 1'b1;
            end
        end
    end

    // Program counter
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pc_ff <= RST_PC;
        end else if (ce) begin
            if (busWrOk && avs_address == OFS_PC) begin
                pc_ff <= PC_W'(beMerge(32'(pc_ff), avs_writedata,
                                       avs_byteenable));
            end else if (execStep) begin
                if (isReturn) begin
                    pc_ff <= stk_ff;
                end else begin
                    pc_ff <= PC_W'(pc_ff + 1'b1);
                end
            end
        end
    end

    // Top stack entry, loaded by software
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stk_ff <= RST_STK;
        end else if (ce && busWrOk && avs_address == OFS_STK) begin
            stk_ff <= PC_W'(beMerge(32'(stk_ff), avs_writedata,
                                    avs_byteenable));
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    assign busy = !idle;
    assign globalInterruptEnable = ien_ff;
    assign progCounter = pc_ff;

endmodule : boeu_top
`default_nettype wire

// ==== core/boeu_pkg.sv ====
package boeu_pkg;

    // ----------------------------------------------------------------
    // Datapath widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int FILE_DEPTH_DEF = 128;

    // ----------------------------------------------------------------
    // Register byte offsets on the Avalon-MM slave
    // ----------------------------------------------------------------
    localparam logic [9:0] OFS_CMD = 10'h000;
    localparam logic [9:0] OFS_STAT = 10'h004;
    localparam logic [9:0] OFS_WREG = 10'h008;
    localparam logic [9:0] OFS_PC = 10'h00c;
    localparam logic [9:0] OFS_STK = 10'h010;
    localparam int FILE_WIN_BIT = 9;

    // ----------------------------------------------------------------
    // Command register fields
    // ----------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 4;
    localparam int CMD_ADR_LSB = 4;
    localparam int CMD_DST_BIT = 11;
    localparam int CMD_LIT_LSB = 12;
    localparam int CMD_W = 20;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int ST_Z_BIT = 0;
    localparam int ST_C_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_IEN_BIT = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CMD_W-1:0] RST_CMD = 20'h00000;
    localparam logic [DATA_W-1:0] RST_WREG = 8'h00;
    localparam logic [PC_W-1:0] RST_PC = 13'h0000;
    localparam logic [PC_W-1:0] RST_STK = 13'h0000;
    localparam logic RST_Z = 1'b0;
    localparam logic RST_C = 1'b0;
    localparam logic RST_IEN = 1'b0;

    // ----------------------------------------------------------------
    // Timing and encodings
    // ----------------------------------------------------------------
    localparam int ICYC_CLKS = 2;
    localparam logic [1:0] HOLD_LOAD = 2'(ICYC_CLKS - 1);
    localparam logic DEST_W = 1'b0;
    localparam logic DEST_F = 1'b1;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_INCREMENT_FILE = 4'h1,
        OP_OR_WITH_FILE = 4'h2,
        OP_MOVE_FILE = 4'h3,
        OP_LOAD_LITERAL = 4'h4,
        OP_RETURN_FROM_INTERRUPT = 4'h5,
        OP_STORE_WORKING_REGISTER = 4'h6,
        OP_RETURN_WITH_LITERAL = 4'h7,
        OP_ROTATE_LEFT_THROUGH_CARRY = 4'h8
    } boeu_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC = 2'b10,
        ST_HOLD = 2'b11
    } boeu_state_e;

endpackage : boeu_pkg

// ==== core/boeu_file_ram.sv ====
`timescale 1ns/100ps
`default_nettype none
module boeu_file_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic we,
    input wire logic re,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    // Refuse sizes the address port cannot reach
    if (DEPTH < 2 || AW < $clog2(DEPTH)) begin : gBadCfg
        $error("DEPTH or AW out of range");
    end

    logic [WIDTH-1:0] memArr [DEPTH];

    // Array write, no reset on storage
    always_ff @(posedge clk_sys) begin
        if (ce && we) begin
            memArr[addr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (ce && re) begin
            rdata <= memArr[addr];
        end
    end

endmodule : boeu_file_ram
`default_nettype wire

// ==== core/boeu_alu.sv ====
`timescale 1ns/100ps
`default_nettype none
module boeu_alu
    import boeu_pkg::*;
(
    input wire boeu_op_e op,
    input wire logic [DATA_W-1:0] fileVal,
    input wire logic [DATA_W-1:0] wVal,
    input wire logic [DATA_W-1:0] lit,
    input wire logic carryIn,
    output logic [DATA_W-1:0] result,
    output logic zero,
    output logic carryOut
);

    // Result per operation
    always_comb begin
        result = wVal;
        carryOut = carryIn;
        case (op)
            OP_INCREMENT_FILE: result = DATA_W'(fileVal + 1'b1);
            OP_OR_WITH_FILE: result = wVal | fileVal;
            OP_MOVE_FILE: result = fileVal;
            OP_LOAD_LITERAL: result = lit;
            OP_RETURN_WITH_LITERAL: result = lit;
            OP_STORE_WORKING_REGISTER: result = wVal;
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
                result = {fileVal[DATA_W-2:0], carryIn};
                carryOut = fileVal[DATA_W-1];
            end
            default: result = wVal;
        endcase
    end

    // Zero detect on the result
    assign zero = (result == '0);

endmodule : boeu_alu
`default_nettype wire

// ==== tb/boeu_top_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module boeu_top_checker
    import boeu_pkg::*;
#(
    parameter int FILE_DEPTH = FILE_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic busy,
    input wire logic globalInterruptEnable,
    input wire logic [PC_W-1:0] progCounter
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b || !ce);

    // --------------------------------------------------------------
    // Command accept decode
    // --------------------------------------------------------------
    logic cmdGo;
    logic rdOk;
    logic [3:0] opc;
    assign cmdGo = avs_write && !avs_waitrequest && ce
                   && avs_address == OFS_CMD;
    assign rdOk = avs_read && !avs_waitrequest;
    assign opc = avs_writedata[3:0];

    // --------------------------------------------------------------
    // Operation length
    // --------------------------------------------------------------
    sequence s_short;
        busy ##1 busy ##1 !busy;
    endsequence
    sequence s_long;
        busy [*4] ##1 !busy;
    endsequence
    property p_short_op;
        cmdGo && opc != 4'h7 |=> s_short;
    endproperty
    a_short_op: assert property (p_short_op)
        else $error("short op length wrong");
    property p_long_op;
        cmdGo && opc == 4'h7 |=> s_long;
    endproperty
    a_long_op: assert property (p_long_op)
        else $error("return with literal length wrong");

    // --------------------------------------------------------------
    // Program counter and interrupt enable
    // --------------------------------------------------------------
    property p_pc_step;
        cmdGo && !(opc inside {4'h5, 4'h7}) |->
            ##3 progCounter == PC_W'($past(progCounter, 3) + 1);
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("program counter did not step by one");
    property p_gie_set;
        cmdGo && opc == 4'h5 |-> ##3 globalInterruptEnable;
    endproperty
    a_gie_set: assert property (p_gie_set)
        else $error("interrupt enable not set");
    property p_gie_keep;
        cmdGo && opc != 4'h5 |->
            ##3 globalInterruptEnable == $past(globalInterruptEnable, 3);
    endproperty
    a_gie_keep: assert property (p_gie_keep)
        else $error("interrupt enable changed");

    // --------------------------------------------------------------
    // Bus behaviour
    // --------------------------------------------------------------
    property p_write_stall;
        busy && avs_write |-> avs_waitrequest;
    endproperty
    a_write_stall: assert property (p_write_stall)
        else $error("write accepted while busy");
    property p_stat_busy;
        rdOk && avs_address == OFS_STAT |->
            avs_readdata[ST_BUSY_BIT] == busy
            && avs_readdata[ST_IEN_BIT] == globalInterruptEnable;
    endproperty
    a_stat_busy: assert property (p_stat_busy)
        else $error("status readback differs from ports");
    property p_pc_read;
        rdOk && avs_address == OFS_PC |->
            avs_readdata == {19'h00000, progCounter};
    endproperty
    a_pc_read: assert property (p_pc_read)
        else $error("program counter readback differs");
endmodule : boeu_top_checker

bind boeu_top boeu_top_checker #(.FILE_DEPTH(FILE_DEPTH)) u_boeu_top_checker (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .busy(busy), .globalInterruptEnable(globalInterruptEnable),
    .progCounter(progCounter)
);
`default_nettype wire

// ==== tb/byte_op_execute_unit_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module byte_op_execute_unit_test
    import boeu_pkg::*;
;
    logic clk_sys, rst_b, ce, avs_read, avs_write, avs_waitrequest, busy;
    logic globalInterruptEnable;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rv;
    logic [3:0] avs_byteenable;
    logic [PC_W-1:0] progCounter, epc, stk;
    int mismatches, checksDone, nb;

    // --------------------------------------------------------------
    // Clock and design
    // --------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    boeu_top u_boeu_top (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .busy(busy),
        .globalInterruptEnable(globalInterruptEnable),
        .progCounter(progCounter));

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task finish_test;
        if (mismatches == 0 && checksDone > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk
    // One Avalon access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 500);
        if (avs_waitrequest !== 1'b0) begin
            mismatches++;
            finish_test;
        end
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task rdc(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask : rdc
    function automatic logic [9:0] fa(input logic [6:0] i);
        return {1'b1, i, 2'b00};
    endfunction : fa
    // Start a command, count busy cycles, check the program counter
    task op(input logic [3:0] o, input logic [6:0] f, input logic dst,
            input logic [7:0] k);
        bus(1'b1, OFS_CMD, {12'h000, k, dst, f, o});
        nb = 0;
        while (nb < 10) begin
            @(posedge clk_sys);
            if (busy !== 1'b1)
                break;
            nb++;
        end
        if (nb == 10) begin
            mismatches++;
            finish_test;
        end
        epc = (o == 4'h5 || o == 4'h7) ? stk : PC_W'(epc + 1);
        chk({19'h00000, progCounter}, {19'h00000, epc});
    endtask : op

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        mismatches = 0;
        checksDone = 0;
        epc = 13'h0000;
        stk = 13'h0000;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(OFS_STAT, 32'h0);
        rdc(OFS_WREG, 32'h0);
        rdc(OFS_PC, 32'h0);
        bus(1'b1, 10'h014, 32'hff);
        rdc(10'h014, 32'h0);
        bus(1'b1, OFS_STAT, 32'h3);
        op(4'h4, 7'h00, 1'b0, 8'hff);
        rdc(OFS_WREG, 32'hff);
        rdc(OFS_STAT, 32'h3);
        op(4'h6, 7'h7f, 1'b0, 8'h00);
        rdc(fa(7'h7f), 32'hff);
        rdc(OFS_STAT, 32'h3);
        op(4'h1, 7'h7f, 1'b1, 8'h00);
        rdc(fa(7'h7f), 32'h0);
        rdc(OFS_STAT, 32'h3);
        op(4'h1, 7'h7f, 1'b0, 8'h00);
        rdc(OFS_WREG, 32'h1);
        rdc(fa(7'h7f), 32'h0);
        rdc(OFS_STAT, 32'h2);
        bus(1'b1, fa(7'h05), 32'h50);
        op(4'h2, 7'h05, 1'b1, 8'h00);
        rdc(fa(7'h05), 32'h51);
        rdc(OFS_WREG, 32'h1);
        op(4'h2, 7'h05, 1'b0, 8'h00);
        rdc(OFS_WREG, 32'h51);
        rdc(OFS_STAT, 32'h2);
        op(4'h3, 7'h7f, 1'b0, 8'h00);
        rdc(OFS_WREG, 32'h0);
        rdc(OFS_STAT, 32'h3);
        op(4'h3, 7'h05, 1'b1, 8'h00);
        rdc(fa(7'h05), 32'h51);
        rdc(OFS_STAT, 32'h2);
        op(4'h8, 7'h05, 1'b1, 8'h00);
        rdc(fa(7'h05), 32'ha3);
        rdc(OFS_STAT, 32'h0);
        bus(1'b1, OFS_STAT, 32'h1);
        op(4'h8, 7'h05, 1'b0, 8'h00);
        rdc(OFS_WREG, 32'h46);
        rdc(fa(7'h05), 32'ha3);
        rdc(OFS_STAT, 32'h3);
        bus(1'b1, OFS_STAT, 32'h0);
        stk = 13'h1abc;
        bus(1'b1, OFS_STK, {19'h00000, stk});
        op(4'h5, 7'h00, 1'b0, 8'h00);
        chk(32'(nb), 32'h2);
        rdc(OFS_STAT, 32'h8);
        stk = 13'h0123;
        bus(1'b1, OFS_STK, {19'h00000, stk});
        op(4'h7, 7'h00, 1'b0, 8'h5a);
        chk(32'(nb), 32'h4);
        rdc(OFS_WREG, 32'h5a);
        op(4'h0, 7'h00, 1'b0, 8'h00);
        chk(32'(nb), 32'h2);
        rdc(OFS_WREG, 32'h5a);
        rdc(OFS_STAT, 32'h8);
        bus(1'b1, OFS_CMD, 32'h0);
        rdc(OFS_STAT, 32'hc);
        epc = PC_W'(epc + 1);
        rdc(OFS_PC, {19'h00000, epc});
        // Freeze mid-operation with the clock enable low
        fork
            op(4'h4, 7'h00, 1'b0, 8'h3c);
            begin
                repeat (3) @(posedge clk_sys);
                ce <= 1'b0;
                repeat (4) @(posedge clk_sys);
                ce <= 1'b1;
            end
        join
        chk(32'(nb), 32'h6);
        rdc(OFS_WREG, 32'h3c);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(OFS_STAT, 32'h0);
        rdc(OFS_PC, 32'h0);
        finish_test;
    end
endmodule : byte_op_execute_unit_test
`default_nettype wire
